// [cbp_pkg.sv]
// package for the crypto and bit permutation datapath: widths, opcodes, carriers, s-box
package cbp_pkg;

	// ==========================================================
	// widths
	localparam int CBP_MAX_XLEN = 64;
	localparam int CBP_NARROW_XLEN = 32;
	localparam int CBP_WIDE_XLEN = 64;
	localparam int CBP_BYTE_W = 8;
	localparam int CBP_NIBBLE_W = 4;
	localparam int CBP_SEL_W = 2;

	// ==========================================================
	// key round step linear layer rotate amounts
	localparam int CBP_KS_ROT_A = 13;
	localparam int CBP_KS_ROT_B = 23;

	// ==========================================================
	// operation select, one-hot
	typedef enum logic [5:0] {
		CBP_OP_KEY_STEP = 6'h01,
		CBP_OP_UNZIP = 6'h02,
		CBP_OP_ZIP = 6'h04,
		CBP_OP_XNOR = 6'h08,
		CBP_OP_BYTE_LUT = 6'h10,
		CBP_OP_NIBBLE_LUT = 6'h20
	} cbp_op_t;

	// ==========================================================
	// request from the pipeline and answer back to writeback
	typedef struct packed {
		logic valid;
		cbp_op_t op;
		logic [CBP_SEL_W-1:0] byte_selector;
		logic [CBP_MAX_XLEN-1:0] first_source_operand;
		logic [CBP_MAX_XLEN-1:0] second_source_operand;
	} cbp_req_t;

	typedef struct packed {
		logic valid;
		logic illegal;
		logic [CBP_MAX_XLEN-1:0] result;
	} cbp_rsp_t;

	// ==========================================================
	// substitution box, entry 0 in the top byte
	localparam logic [2047:0] CBP_SBOX = {
		128'hD690E9FECCE13DB716B614C228FB2C05,
		128'h2B679A762ABE04C3AA44132649860699,
		128'h9C4250F491EF987A33540B43EDCFAC62,
		128'hE4B31CA9C908E89580DF94FA758F3FA6,
		128'h4707A7FCF37317BA83593C19E6854FA8,
		128'h686B81B27164DA8BF8EB0F4B70569D35,
		128'h1E240E5E6358D1A225227C3B01217887,
		128'hD40046579FD327524C3602E7A0C4C89E,
		128'hEABF8AD240C738B5A3F7F2CEF96115A1,
		128'hE0AE5DA49B341A55AD933230F58CB1E3,
		128'h1DF6E22E8266CA60C02923AB0D534E6F,
		128'hD5DB3745DEFD8E2F03FF6A726D6C5B51,
		128'h8D1BAF92BBDDBC7F11D95C411F105AD8,
		128'h0AC13188A5CD7BBD2D74D012B8E5B4B0,
		128'h8969974A0C96777E65B9F109C56EC684,
		128'h18F07DEC3ADC4D2079EE5F3ED7CB3948
	};

endpackage

// [cbp_alu.sv]
// datapath for key round step, bit zip/unzip, xnor and register table lookups
module cbp_alu #(
	parameter int XLEN = 32
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input cbp_pkg::cbp_req_t req,
	output cbp_pkg::cbp_rsp_t rsp
);
	import cbp_pkg::*;

	// half width for the bit moves, word width for the key step
	localparam int HALF = XLEN / 2;
	localparam int WORD = CBP_NARROW_XLEN;

	// ==========================================================
	// helpers

	// constant-time sbox: full mux over the constant table
	function automatic logic [CBP_BYTE_W-1:0] sbox(input logic [CBP_BYTE_W-1:0] x);
		sbox = CBP_SBOX[$bits(CBP_SBOX) - 1 - CBP_BYTE_W * int'(x) -: CBP_BYTE_W];
	endfunction

	// rotate left within one 32-bit word
	function automatic logic [WORD-1:0] rol(input logic [WORD-1:0] x, input int n);
		rol = (x << n) | (x >> (WORD - n));
	endfunction

	// shared table lookup for byte and nibble element widths
	function automatic logic [XLEN-1:0] lookup(input logic [XLEN-1:0] tbl,
		input logic [XLEN-1:0] idx, input int ew);
		logic [XLEN-1:0] r;
		logic [XLEN-1:0] sh;
		int k;
		r = '0;
		for (int i = 0; i < XLEN; i += ew) begin
			k = 0;
			for (int j = 0; j < ew; j++) begin
				k = k | (int'(idx[i+j]) << j);
			end
			// index beyond the table shifts everything out, leaving zero
			sh = (k * ew >= XLEN) ? '0 : (tbl >> (k * ew));
			for (int j = 0; j < ew; j++) begin
				r[i+j] = sh[j];
			end
		end
		lookup = r;
	endfunction

	// ==========================================================
	// operand views
	// only the low configured width is used, so upper bits left over in a
	// wide pipeline register cannot leak into a narrow result
	logic [XLEN-1:0] opa;
	logic [XLEN-1:0] opb;
	assign opa = req.first_source_operand[XLEN-1:0];
	assign opb = req.second_source_operand[XLEN-1:0];

	// ==========================================================
	// key round step
	// every stage is plain combinational logic with no early exit, so the
	// answer time never depends on the operand values
	logic [CBP_BYTE_W-1:0] ks_in;
	logic [WORD-1:0] ks_x;
	logic [WORD-1:0] ks_y;
	logic [WORD-1:0] ks_z;
	logic [WORD-1:0] ks_word;
	logic [XLEN-1:0] ks_res;
	int ks_shamt;

	// bit offset of the selected byte lane
	always_comb begin
		ks_shamt = int'(req.byte_selector) * CBP_BYTE_W;
	end

	// byte pick from the second operand, then substitution
	always_comb begin
		ks_in = opb[ks_shamt +: CBP_BYTE_W];
		ks_x = WORD'(sbox(ks_in));
	end

	// linear layer on the lone byte, then rotate into its lane;
	// rotation distributes over xor, so rotating last gives the same word
	always_comb begin
		ks_y = ks_x ^ rol(ks_x, CBP_KS_ROT_A) ^ rol(ks_x, CBP_KS_ROT_B);
		ks_z = (ks_shamt == 0) ? ks_y : rol(ks_y, ks_shamt);
	end

	// fold in the first operand, sign-extend to the register width
	always_comb begin
		ks_word = ks_z ^ opa[WORD-1:0];
		ks_res = XLEN'(signed'(ks_word));
	end

	// ==========================================================
	// bit de-interleave and interleave, both fixed wiring
	logic [XLEN-1:0] unzip_res;
	logic [XLEN-1:0] zip_res;

	// de-interleave: even bits to the low half, odd bits to the high half
	always_comb begin
		unzip_res = '0;
		for (int i = 0; i < HALF; i++) begin
			unzip_res[i] = opa[2*i];
			unzip_res[i+HALF] = opa[2*i+1];
		end
	end

	// interleave: the exact inverse of the wiring above
	always_comb begin
		zip_res = '0;
		for (int i = 0; i < HALF; i++) begin
			zip_res[2*i] = opa[i];
			zip_res[2*i+1] = opa[i+HALF];
		end
	end

	// ==========================================================
	// register table lookups
	logic [XLEN-1:0] byte_lut_res;
	logic [XLEN-1:0] nibble_lut_res;

	// both element widths are worked out every cycle; the select picks one
	always_comb begin
		byte_lut_res = lookup(opa, opb, CBP_BYTE_W);
		nibble_lut_res = lookup(opa, opb, CBP_NIBBLE_W);
	end

	// ==========================================================
	// exclusive-nor over the full register width
	logic [XLEN-1:0] xnor_res;

	assign xnor_res = ~(opa ^ opb);

	// ==========================================================
	// zip and unzip exist on the narrow config only
	localparam bit ZIP_OK = (XLEN == CBP_NARROW_XLEN);

	// ==========================================================
	// result select; unsupported combinations answer zero, flagged illegal,
	// so a stray op never leaves a partial result behind
	logic [XLEN-1:0] next_result;
	logic next_illegal;

	always_comb begin
		next_result = '0;
		next_illegal = 1'b0;
		case (req.op)
			CBP_OP_KEY_STEP: begin
				next_result = ks_res;
			end
			CBP_OP_UNZIP: begin
				if (ZIP_OK) begin
					next_result = unzip_res;
				end else begin
					next_illegal = 1'b1;
				end
			end
			CBP_OP_ZIP: begin
				if (ZIP_OK) begin
					next_result = zip_res;
				end else begin
					next_illegal = 1'b1;
				end
			end
			CBP_OP_XNOR: begin
				next_result = xnor_res;
			end
			CBP_OP_BYTE_LUT: begin
				next_result = byte_lut_res;
			end
			CBP_OP_NIBBLE_LUT: begin
				next_result = nibble_lut_res;
			end
			default: begin
				next_illegal = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// answer register: every operation retires exactly one cycle later,
	// whatever the op or data, so the pipeline never stalls on this unit

	// answer strobe, one cycle per request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rsp.valid <= 1'b0;
		end else begin
			rsp.valid <= req.valid;
		end
	end

	// illegal flag, held until the next request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rsp.illegal <= 1'b0;
		end else if (req.valid) begin
			rsp.illegal <= next_illegal;
		end
	end

	// result word, zero above the configured width
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rsp.result <= '0;
		end else if (req.valid) begin
			rsp.result <= CBP_MAX_XLEN'(next_result);
		end
	end

endmodule // cbp_alu

// [cbp_wb_model.sv]
// writeback side model: queues every answer of the datapath
module cbp_wb_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input cbp_pkg::cbp_rsp_t rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [64:0] got[$];
	// answer taken in the one cycle its valid stands
	always @(posedge sys_clk) begin
		if (nrst && rsp.valid === 1'b1) begin
			got.push_back({rsp.illegal, rsp.result});
		end
	end
endmodule // cbp_wb_model

// [cbp_alu_monitor.sv]
// checker on the datapath ports
module cbp_alu_monitor import cbp_pkg::*; #(
	parameter int XLEN = 32
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input cbp_pkg::cbp_req_t req,
	input cbp_pkg::cbp_rsp_t rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [63:0] a = req.first_source_operand;
	wire [63:0] b = req.second_source_operand;
	wire go = req.valid;
	logic [7:0] pick;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	// lane 0 byte the lookup should return
	always_ff @(posedge sys_clk) begin
		pick <= 8'(a >> (b[7:0] * 8));
	end
	// ==========
	// timing, bit moves, lookups
	a_answer_next: assert property (go |=> rsp.valid)
		else $error("late answer");
	a_idle_quiet: assert property (!go |=> !rsp.valid)
		else $error("stray answer");
	a_xnor_bits: assert property (go && req.op == CBP_OP_XNOR |=>
		rsp.result[31:0] == 32'(~($past(a) ^ $past(b)))) else $error("xnor");
	a_unzip_odd: assert property (go && req.op == CBP_OP_UNZIP |=>
		rsp.result[31] == $past(a[31]) && rsp.result[15] == $past(a[30])) else $error("unzip");
	a_zip_half: assert property (go && req.op == CBP_OP_ZIP |=>
		rsp.result[31] == $past(a[31]) && rsp.result[30] == $past(a[15])) else $error("zip");
	a_byte_pick: assert property (go && req.op == CBP_OP_BYTE_LUT && b[7:0] < XLEN / 8
		|=> rsp.result[7:0] == pick) else $error("byte pick");
	a_byte_zero: assert property (go && req.op == CBP_OP_BYTE_LUT && b[7:0] >= XLEN / 8
		|=> rsp.result[7:0] == 8'h00) else $error("byte range");
	a_nib_zero: assert property (go && req.op == CBP_OP_NIBBLE_LUT && b[3:0] >= XLEN / 4
		|=> rsp.result[3:0] == 4'h0) else $error("nibble range");
endmodule // cbp_alu_monitor
bind cbp_alu cbp_alu_monitor #(.XLEN(XLEN)) cbp_alu_monitor_inst (.sys_clk(sys_clk),
	.nrst(nrst), .req(req), .rsp(rsp));

// [cbp_alu_test.sv]
// bench: random requests against a reference model
module cbp_alu_test import cbp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	cbp_req_t req = '0;
	cbp_req_t r;
	cbp_rsp_t rsp;
	int err_total = 0;
	int checks_done = 0;
	integer seed = 32'hB49E;
	logic [64:0] ex[$];
	logic [5:0] ops[7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h03};
	cbp_alu #(.XLEN(32)) cbp_alu_inst (.sys_clk(sys_clk), .nrst(nrst), .req(req), .rsp(rsp));
	cbp_wb_model cbp_wb_model_inst (.sys_clk(sys_clk), .nrst(nrst), .rsp(rsp));
	function automatic logic [31:0] rol(logic [31:0] x, int k);
		return (x << k) | (x >> (32 - k));
	endfunction
	// reference answer, illegal flag on top
	function automatic logic [64:0] ref_ans(cbp_req_t q);
		logic [31:0] a = q.first_source_operand[31:0];
		logic [31:0] b = q.second_source_operand[31:0];
		logic [31:0] y = 32'h0;
		int s = 8 * q.byte_selector;
		case (q.op)
			CBP_OP_KEY_STEP: begin
				y[7:0] = CBP_SBOX[2047 - 8 * b[s +: 8] -: 8];
				y = rol(y ^ rol(y, 13) ^ rol(y, 23), s) ^ a;
			end
			CBP_OP_UNZIP: for (int i = 0; i < 16; i++) begin
				y[i] = a[2 * i];
				y[i + 16] = a[2 * i + 1];
			end
			CBP_OP_ZIP: for (int i = 0; i < 16; i++) begin
				y[2 * i] = a[i];
				y[2 * i + 1] = a[i + 16];
			end
			CBP_OP_XNOR: y = ~(a ^ b);
			CBP_OP_BYTE_LUT: for (int i = 0; i < 32; i += 8) begin
				y[i +: 8] = b[i +: 8] < 4 ? a[8 * b[i +: 8] +: 8] : 8'h00;
			end
			CBP_OP_NIBBLE_LUT: for (int i = 0; i < 32; i += 4) begin
				y[i +: 4] = b[i +: 4] < 8 ? a[4 * b[i +: 4] +: 4] : 4'h0;
			end
			default: return {1'b1, 64'h0};
		endcase
		return {33'h0, y};
	endfunction
	task automatic chk(logic [64:0] got, logic [64:0] want);
		checks_done++;
		if (got !== want) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end
	// watchdog well past the expected run
	initial begin
		repeat (2000) @(posedge sys_clk);
		err_total++;
		wrap_up();
	end
	// back-to-back random requests with gaps, every opcode in turn
	initial begin
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int n = 0; n < 350; n++) begin
			@(posedge sys_clk);
			r.valid = ($random(seed) & 3) != 0;
			r.op = cbp_op_t'(ops[n % 7]);
			r.byte_selector = 2'($random(seed));
			r.first_source_operand = {$random(seed), $random(seed)};
			r.second_source_operand = {$random(seed), $random(seed) & (n[3] ? -1 : 32'h07070707)};
			req <= r;
			if (r.valid) begin
				ex.push_back(ref_ans(r));
			end
		end
		@(posedge sys_clk);
		req.valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(65'(cbp_wb_model_inst.got.size()), 65'(ex.size()));
		foreach (ex[i]) begin
			chk(cbp_wb_model_inst.got[i], ex[i]);
		end
		$display("random operation test done");
		wrap_up();
	end
endmodule // cbp_alu_test
